// file: src/bit_logic_pkg.sv
// Constants, types and cycle costs for the carry, rotate and bit logic unit.
// Assumes one CPU clock; every instruction clock equals one period of it.
//
// Contract
// - Rotate right through carry: A bit0 to carry, old carry to bit7, 2 clocks.
// - Rotate left through carry: A bit7 to carry, old carry to bit0, 2 clocks.
// - Nibble rotate right with pointed byte; 10 clocks fast RAM, else 12.
// - Nibble rotate left with pointed byte; 10 or 12 clocks, flags untouched.
// - Decimal adjust after add fixes A to BCD, sets Z, AC, CY; 4 clocks.
// - Decimal adjust after subtract fixes A to BCD, sets Z, AC, CY; 4 clocks.
// - Carry AND with one bit from five sources; only carry changes.
// - Carry OR with one bit from the same five sources; only carry changes.
// - Carry XOR with one bit from the same five sources; only carry changes.
// - First clock figure for fast RAM or no data; register and status forms take second.
// - Second clock figure for any other area; bit stores take 8 not 6.
// - Each counted clock is one period of the CPU clock.
// - Counts hold for programs running from internal program ROM.

package bit_logic_pkg;

    // ------------------------------------------------------------------
    // Status word layout and reset values
    // ------------------------------------------------------------------
    localparam int unsigned PSW_Z_POS   = 6;
    localparam int unsigned PSW_AC_POS  = 4;
    localparam int unsigned PSW_CY_POS  = 0;
    localparam logic [7:0]  ACC_RESET   = 8'h00;
    localparam logic [7:0]  PSW_RESET   = 8'h00;
    localparam logic [7:0]  BCD_LO_FIX  = 8'h06;
    localparam logic [7:0]  BCD_HI_FIX  = 8'h60;
    localparam logic [7:0]  BCD_MAX     = 8'h99;
    localparam logic [3:0]  NIB_MAX     = 4'h9;

    // ------------------------------------------------------------------
    // Instruction clock counts
    // ------------------------------------------------------------------
    localparam logic [3:0]  CYC_SHORT     = 4'h2;
    localparam logic [3:0]  CYC_ADJUST    = 4'h4;
    localparam logic [3:0]  CYC_NIB_FAST  = 4'hA;
    localparam logic [3:0]  CYC_NIB_SLOW  = 4'hC;
    localparam logic [3:0]  CYC_ACC_BIT   = 4'h4;
    localparam logic [3:0]  CYC_RD_FAST   = 4'h6;
    localparam logic [3:0]  CYC_RD_SLOW   = 4'h7;
    localparam logic [3:0]  CYC_WR_FAST   = 4'h6;
    localparam logic [3:0]  CYC_WR_SLOW   = 4'h8;
    localparam logic [3:0]  CYC_SET_SHORT = 4'h4;
    localparam logic [3:0]  CYC_SET_SADDR = 4'h6;
    localparam logic [3:0]  CYC_SET_PSW   = 4'h6;
    localparam logic [3:0]  CYC_COUNT_ONE = 4'h1;

    // ------------------------------------------------------------------
    // Operations, bit sources, states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_ROT_R     = 4'h0,
        OP_ROT_L     = 4'h1,
        OP_NIB_R     = 4'h2,
        OP_NIB_L     = 4'h3,
        OP_ADJ_ADD   = 4'h4,
        OP_ADJ_SUB   = 4'h5,
        OP_MOVE_IN   = 4'h6,
        OP_MOVE_OUT  = 4'h7,
        OP_C_AND     = 4'h8,
        OP_C_OR      = 4'h9,
        OP_C_XOR     = 4'hA,
        OP_BIT_SET   = 4'hB,
        OP_BIT_CLR   = 4'hC,
        OP_CY_SET    = 4'hD,
        OP_CY_CLR    = 4'hE,
        OP_CY_NOT    = 4'hF
    } op_e;

    typedef enum logic [2:0] {
        SRC_SADDR = 3'h0,
        SRC_SFR   = 3'h1,
        SRC_ACC   = 3'h2,
        SRC_PSW   = 3'h3,
        SRC_PTR   = 3'h4
    } src_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } state_e;

    typedef struct packed {
        op_e        op;
        src_e       src;
        logic [2:0] bit_idx;
        logic       fast_ram;
        logic [7:0] mem_data;
    } req_s;

    typedef struct packed {
        logic       we;
        logic [7:0] data;
    } mem_wr_s;

endpackage : bit_logic_pkg

// file: src/carry_rotate_bit_logic_unit.sv
// Execution unit for carry rotates, nibble rotates, decimal adjust and bit logic.
// Assumes the core fetches the pointed or direct byte and presents it with the
// request, and performs the memory write that this unit issues at completion.

`timescale 1ns/100ps

module carry_rotate_bit_logic_unit (
    // Clock and reset
    input  wire logic                 SYS_CLK,
    input  wire logic                 RESETN,
    // Instruction request
    input  wire logic                 START,
    input  wire bit_logic_pkg::req_s  REQ,
    output logic                      READY,
    output logic                      DONE,
    // Accumulator and status word load
    input  wire logic                 ACC_LOAD,
    input  wire logic [7:0]           ACC_IN,
    input  wire logic                 PSW_LOAD,
    input  wire logic [7:0]           PSW_IN,
    // Architectural state
    output logic [7:0]                ACC_OUT,
    output logic [7:0]                PSW_OUT,
    // Memory write back
    output bit_logic_pkg::mem_wr_s    MEM_WR
);

    // ------------------------------------------------------------------
    // Cycle cost lookup
    // ------------------------------------------------------------------
    function automatic logic [3:0] cost(input bit_logic_pkg::req_s r);
        logic slow;
        slow = ~r.fast_ram;
        cost = bit_logic_pkg::CYC_SHORT;
        case (r.op)
            bit_logic_pkg::OP_NIB_R, bit_logic_pkg::OP_NIB_L: begin
                cost = slow ? bit_logic_pkg::CYC_NIB_SLOW : bit_logic_pkg::CYC_NIB_FAST;
            end
            bit_logic_pkg::OP_ADJ_ADD, bit_logic_pkg::OP_ADJ_SUB: begin
                cost = bit_logic_pkg::CYC_ADJUST;
            end
            bit_logic_pkg::OP_MOVE_IN, bit_logic_pkg::OP_C_AND,
            bit_logic_pkg::OP_C_OR, bit_logic_pkg::OP_C_XOR: begin
                case (r.src)
                    bit_logic_pkg::SRC_ACC: cost = bit_logic_pkg::CYC_ACC_BIT;
                    bit_logic_pkg::SRC_SFR, bit_logic_pkg::SRC_PSW: cost = bit_logic_pkg::CYC_RD_SLOW;
                    default: cost = slow ? bit_logic_pkg::CYC_RD_SLOW : bit_logic_pkg::CYC_RD_FAST;
                endcase
            end
            bit_logic_pkg::OP_MOVE_OUT: begin
                case (r.src)
                    bit_logic_pkg::SRC_ACC: cost = bit_logic_pkg::CYC_ACC_BIT;
                    bit_logic_pkg::SRC_SFR, bit_logic_pkg::SRC_PSW: cost = bit_logic_pkg::CYC_WR_SLOW;
                    default: cost = slow ? bit_logic_pkg::CYC_WR_SLOW : bit_logic_pkg::CYC_WR_FAST;
                endcase
            end
            bit_logic_pkg::OP_BIT_SET, bit_logic_pkg::OP_BIT_CLR: begin
                case (r.src)
                    bit_logic_pkg::SRC_ACC: cost = bit_logic_pkg::CYC_SET_SHORT;
                    bit_logic_pkg::SRC_SFR: cost = bit_logic_pkg::CYC_WR_SLOW;
                    bit_logic_pkg::SRC_PSW: cost = bit_logic_pkg::CYC_SET_PSW;
                    bit_logic_pkg::SRC_SADDR: begin
                        cost = slow ? bit_logic_pkg::CYC_SET_SADDR : bit_logic_pkg::CYC_SET_SHORT;
                    end
                    default: cost = slow ? bit_logic_pkg::CYC_WR_SLOW : bit_logic_pkg::CYC_WR_FAST;
                endcase
            end
            default: cost = bit_logic_pkg::CYC_SHORT;
        endcase
    endfunction : cost

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    bit_logic_pkg::state_e state_reg;
    bit_logic_pkg::state_e state_next;
    bit_logic_pkg::req_s   req_reg;
    bit_logic_pkg::req_s   req_next;
    logic [3:0]            count_reg;
    logic [3:0]            count_next;
    logic                  accept;
    logic                  commit;

    assign READY  = (state_reg == bit_logic_pkg::ST_IDLE);
    assign accept = START & READY;
    // Completion falls on the last counted CPU clock
    assign commit = (state_reg == bit_logic_pkg::ST_EXEC) && (count_reg == bit_logic_pkg::CYC_COUNT_ONE);
    assign DONE   = commit;

    always_comb begin
        state_next = state_reg;
        req_next   = req_reg;
        count_next = count_reg;
        case (state_reg)
            bit_logic_pkg::ST_IDLE: begin
                if (accept) begin
                    state_next = bit_logic_pkg::ST_EXEC;
                    req_next   = REQ;
                    count_next = cost(REQ);
                end
            end
            bit_logic_pkg::ST_EXEC: begin
                count_next = count_reg - bit_logic_pkg::CYC_COUNT_ONE;
                if (commit) begin
                    state_next = bit_logic_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = bit_logic_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= bit_logic_pkg::ST_IDLE;
            req_reg   <= '0;
            count_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            req_reg   <= req_next;
            count_reg <= count_next;
        end
    end

    // ------------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------------
    logic [7:0]           acc_reg;
    logic [7:0]           acc_next;
    logic [7:0]           psw_reg;
    logic [7:0]           psw_next;
    bit_logic_pkg::mem_wr_s wr_reg;
    bit_logic_pkg::mem_wr_s wr_next;
    logic                 cy;
    logic                 ac;
    logic                 sel_bit;
    logic [7:0]           src_byte;
    logic [7:0]           mask;
    logic                 lo_fix;
    logic                 hi_fix;
    logic [7:0]           adj;
    logic [4:0]           lo_sum;

    assign cy   = psw_reg[bit_logic_pkg::PSW_CY_POS];
    assign ac   = psw_reg[bit_logic_pkg::PSW_AC_POS];
    assign mask = 8'h01 << req_reg.bit_idx;
    assign lo_sum = {1'b0, acc_reg[3:0]} + {1'b0, bit_logic_pkg::BCD_LO_FIX[3:0]};

    always_comb begin
        case (req_reg.src)
            bit_logic_pkg::SRC_ACC: src_byte = acc_reg;
            bit_logic_pkg::SRC_PSW: src_byte = psw_reg;
            default:                src_byte = req_reg.mem_data;
        endcase
    end
    assign sel_bit = src_byte[req_reg.bit_idx];

    always_comb begin
        acc_next = acc_reg;
        psw_next = psw_reg;
        wr_next  = '0;
        lo_fix   = 1'b0;
        hi_fix   = 1'b0;
        adj      = acc_reg;
        if (READY) begin
            if (ACC_LOAD) begin
                acc_next = ACC_IN;
            end
            if (PSW_LOAD) begin
                psw_next = PSW_IN;
            end
        end else if (commit) begin
            case (req_reg.op)
                bit_logic_pkg::OP_ROT_R: begin
                    acc_next = {cy, acc_reg[7:1]};
                    psw_next[bit_logic_pkg::PSW_CY_POS] = acc_reg[0];
                end
                bit_logic_pkg::OP_ROT_L: begin
                    acc_next = {acc_reg[6:0], cy};
                    psw_next[bit_logic_pkg::PSW_CY_POS] = acc_reg[7];
                end
                bit_logic_pkg::OP_NIB_R: begin
                    acc_next[3:0] = req_reg.mem_data[3:0];
                    wr_next.we    = 1'b1;
                    wr_next.data  = {acc_reg[3:0], req_reg.mem_data[7:4]};
                end
                bit_logic_pkg::OP_NIB_L: begin
                    acc_next[3:0] = req_reg.mem_data[7:4];
                    wr_next.we    = 1'b1;
                    wr_next.data  = {req_reg.mem_data[3:0], acc_reg[3:0]};
                end
                bit_logic_pkg::OP_ADJ_ADD: begin
                    lo_fix = ac || (acc_reg[3:0] > bit_logic_pkg::NIB_MAX);
                    hi_fix = cy || (acc_reg > bit_logic_pkg::BCD_MAX);
                    adj    = acc_reg + (lo_fix ? bit_logic_pkg::BCD_LO_FIX : 8'h00)
                                     + (hi_fix ? bit_logic_pkg::BCD_HI_FIX : 8'h00);
                    acc_next = adj;
                    psw_next[bit_logic_pkg::PSW_AC_POS] = lo_fix & lo_sum[4];
                    psw_next[bit_logic_pkg::PSW_CY_POS] = hi_fix;
                    psw_next[bit_logic_pkg::PSW_Z_POS]  = (adj == 8'h00);
                end
                bit_logic_pkg::OP_ADJ_SUB: begin
                    lo_fix = ac;
                    hi_fix = cy;
                    adj    = acc_reg - (lo_fix ? bit_logic_pkg::BCD_LO_FIX : 8'h00)
                                     - (hi_fix ? bit_logic_pkg::BCD_HI_FIX : 8'h00);
                    acc_next = adj;
                    psw_next[bit_logic_pkg::PSW_AC_POS] = lo_fix & (acc_reg[3:0] < bit_logic_pkg::BCD_LO_FIX[3:0]);
                    psw_next[bit_logic_pkg::PSW_CY_POS] = hi_fix;
                    psw_next[bit_logic_pkg::PSW_Z_POS]  = (adj == 8'h00);
                end
                bit_logic_pkg::OP_MOVE_IN: psw_next[bit_logic_pkg::PSW_CY_POS] = sel_bit;
                bit_logic_pkg::OP_C_AND:   psw_next[bit_logic_pkg::PSW_CY_POS] = cy & sel_bit;
                bit_logic_pkg::OP_C_OR:    psw_next[bit_logic_pkg::PSW_CY_POS] = cy | sel_bit;
                bit_logic_pkg::OP_C_XOR:   psw_next[bit_logic_pkg::PSW_CY_POS] = cy ^ sel_bit;
                bit_logic_pkg::OP_MOVE_OUT, bit_logic_pkg::OP_BIT_SET, bit_logic_pkg::OP_BIT_CLR: begin
                    // Value written to the selected bit
                    lo_fix = (req_reg.op == bit_logic_pkg::OP_MOVE_OUT) ? cy
                           : (req_reg.op == bit_logic_pkg::OP_BIT_SET);
                    adj    = lo_fix ? (src_byte | mask) : (src_byte & ~mask);
                    case (req_reg.src)
                        bit_logic_pkg::SRC_ACC: acc_next = adj;
                        bit_logic_pkg::SRC_PSW: psw_next = adj;
                        default: begin
                            wr_next.we   = 1'b1;
                            wr_next.data = adj;
                        end
                    endcase
                end
                bit_logic_pkg::OP_CY_SET: psw_next[bit_logic_pkg::PSW_CY_POS] = 1'b1;
                bit_logic_pkg::OP_CY_CLR: psw_next[bit_logic_pkg::PSW_CY_POS] = 1'b0;
                bit_logic_pkg::OP_CY_NOT: psw_next[bit_logic_pkg::PSW_CY_POS] = ~cy;
                default: begin
                    acc_next = acc_reg;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            acc_reg <= bit_logic_pkg::ACC_RESET;
            psw_reg <= bit_logic_pkg::PSW_RESET;
            wr_reg  <= '0;
        end else begin
            acc_reg <= acc_next;
            psw_reg <= psw_next;
            wr_reg  <= wr_next;
        end
    end

    assign ACC_OUT = acc_reg;
    assign PSW_OUT = psw_reg;
    assign MEM_WR  = wr_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [7:0] a_start_reg;
    logic       cy_start_reg;
    logic [7:0] psw_start_reg;
    logic       bit_start_reg;

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            a_start_reg   <= 8'h00;
            cy_start_reg  <= 1'b0;
            psw_start_reg <= 8'h00;
            bit_start_reg <= 1'b0;
        end else if (state_reg == bit_logic_pkg::ST_EXEC && count_reg == cost(req_reg)) begin
            a_start_reg   <= acc_reg;
            cy_start_reg  <= cy;
            psw_start_reg <= psw_reg;
            bit_start_reg <= sel_bit;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    sequence s_take(bit_logic_pkg::op_e o);
        accept && REQ.op == o;
    endsequence

    a_rotate_right_thru_carry_timing: assert property (s_take(bit_logic_pkg::OP_ROT_R) |-> !DONE ##2 DONE)
        else $error("rotate right did not finish in 2 clocks");
    a_rotate_right_thru_carry_value: assert property (DONE && req_reg.op == bit_logic_pkg::OP_ROT_R |=>
        acc_reg == {cy_start_reg, a_start_reg[7:1]} && cy == a_start_reg[0]
        && psw_reg[bit_logic_pkg::PSW_Z_POS] == psw_start_reg[bit_logic_pkg::PSW_Z_POS])
        else $error("rotate right result wrong");
    a_rotate_left_thru_carry_value: assert property (DONE && req_reg.op == bit_logic_pkg::OP_ROT_L |=>
        acc_reg == {a_start_reg[6:0], cy_start_reg} && cy == a_start_reg[7])
        else $error("rotate left result wrong");
    a_nib_fast: assert property (s_take(bit_logic_pkg::OP_NIB_R) ##0 REQ.fast_ram |-> ##10 DONE ##1
        MEM_WR.we && MEM_WR.data == {a_start_reg[3:0], req_reg.mem_data[7:4]})
        else $error("right nibble rotate wrong in fast RAM");
    a_nib_slow: assert property (s_take(bit_logic_pkg::OP_NIB_L) ##0 !REQ.fast_ram |->
        ##1 !DONE[*8] ##1 !DONE[*3] ##1 DONE)
        else $error("left nibble rotate not 12 clocks");
    a_adjust_time: assert property (s_take(bit_logic_pkg::OP_ADJ_ADD) |-> ##4 DONE)
        else $error("decimal adjust not 4 clocks");
    a_carry_and: assert property (DONE && req_reg.op == bit_logic_pkg::OP_C_AND |=>
        cy == (cy_start_reg & bit_start_reg) && acc_reg == a_start_reg)
        else $error("carry and wrong");
    a_carry_or: assert property (DONE && req_reg.op == bit_logic_pkg::OP_C_OR |=> cy == (cy_start_reg | bit_start_reg))
        else $error("carry or wrong");
    a_carry_xor: assert property (DONE && req_reg.op == bit_logic_pkg::OP_C_XOR |=> cy == (cy_start_reg ^ bit_start_reg))
        else $error("carry xor wrong");
    a_sfr_slow: assert property (accept && REQ.op == bit_logic_pkg::OP_C_AND && REQ.src == bit_logic_pkg::SRC_SFR
        && REQ.fast_ram |-> ##7 DONE)
        else $error("register bit form did not take second figure");
    a_store_slow: assert property (accept && REQ.op == bit_logic_pkg::OP_MOVE_OUT && REQ.src == bit_logic_pkg::SRC_PTR
        && !REQ.fast_ram |-> ##8 DONE)
        else $error("slow bit store not 8 clocks");
    a_done_pulse: assert property (DONE |=> !DONE && READY)
        else $error("done lasted more than one clock");

endmodule : carry_rotate_bit_logic_unit

// file: tb/tb.sv
// Self-checking bench for the carry, rotate and bit logic unit.
// Assumes one 50 MHz clock and the unit's START, READY and DONE request handshake.
`timescale 1ns/100ps
module tb;
    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    logic                   SYS_CLK     = 1'b0;
    logic                   RESETN      = 1'b0;
    logic                   START       = 1'b0;
    bit_logic_pkg::req_s    REQ         = '0;
    logic                   ACC_LOAD    = 1'b0;
    logic [7:0]             ACC_IN      = 8'h00;
    logic                   PSW_LOAD    = 1'b0;
    logic [7:0]             PSW_IN      = 8'h00;
    logic                   READY;
    logic                   DONE;
    logic [7:0]             ACC_OUT;
    logic [7:0]             PSW_OUT;
    bit_logic_pkg::mem_wr_s MEM_WR;
    int                     err_total   = 0;
    int                     checks_done = 0;
    logic [31:0]            rng         = 32'h00007B51;
    logic [7:0]             ma          = 8'h00;
    logic [7:0]             mp          = 8'h00;
    logic [7:0]             ea, ep, emd;
    logic                   ewe;
    int                     ecyc;

    always #10 SYS_CLK = ~SYS_CLK;

    carry_rotate_bit_logic_unit uut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .START(START), .REQ(REQ),
        .READY(READY), .DONE(DONE), .ACC_LOAD(ACC_LOAD), .ACC_IN(ACC_IN), .PSW_LOAD(PSW_LOAD),
        .PSW_IN(PSW_IN), .ACC_OUT(ACC_OUT), .PSW_OUT(PSW_OUT), .MEM_WR(MEM_WR));

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Expected accumulator, status word, write back and clock cost
    task automatic predict(input logic [7:0] a, p, m, input int op, src, bi, input logic f);
        logic [7:0] s, w, r;
        logic       cy, lo, hi;
        cy = p[0]; ea = a; ep = p; ewe = 1'b0; emd = 8'h00; ecyc = 2;
        s = (src == 2) ? a : (src == 3) ? p : m;
        w = s;
        w[bi] = (op == 7) ? cy : (op == 11);
        case (op)
            0: begin ea = {cy, a[7:1]}; ep[0] = a[0]; end
            1: begin ea = {a[6:0], cy}; ep[0] = a[7]; end
            2: begin ea = {a[7:4], m[3:0]}; ewe = 1'b1; emd = {a[3:0], m[7:4]}; ecyc = f ? 10 : 12; end
            3: begin ea = {a[7:4], m[7:4]}; ewe = 1'b1; emd = {m[3:0], a[3:0]}; ecyc = f ? 10 : 12; end
            4: begin
                lo = p[4] | (a[3:0] > 4'h9);
                hi = cy | (a > 8'h99);
                r = a + (lo ? 8'h06 : 8'h00) + (hi ? 8'h60 : 8'h00);
                ea = r; ep[4] = a[3:0] > 4'h9; ep[0] = hi; ep[6] = (r == 8'h00); ecyc = 4;
            end
            5: begin
                r = a - (p[4] ? 8'h06 : 8'h00) - (cy ? 8'h60 : 8'h00);
                ea = r; ep[4] = p[4] & (a[3:0] < 4'h6); ep[6] = (r == 8'h00); ecyc = 4;
            end
            6, 8, 9, 10: ep[0] = (op == 6) ? s[bi] : (op == 8) ? cy & s[bi] : (op == 9) ? cy | s[bi] : cy ^ s[bi];
            7, 11, 12: begin
                if (src == 2) ea = w;
                else if (src == 3) ep = w;
                else begin ewe = 1'b1; emd = w; end
            end
            13: ep[0] = 1'b1;
            14: ep[0] = 1'b0;
            default: ep[0] = ~cy;
        endcase
        if (op == 7 || op == 11 || op == 12) begin
            ecyc = (src == 2) ? 4 : (src == 1) ? 8 : (src == 3) ? ((op == 7) ? 8 : 6) :
                   (src == 0 && op != 7) ? (f ? 4 : 6) : (f ? 6 : 8);
        end else if (op >= 6 && op <= 10) begin
            ecyc = (src == 2) ? 4 : (src == 1 || src == 3) ? 7 : (f ? 6 : 7);
        end
    endtask : predict

    task automatic load(input logic [7:0] a, p);
        ACC_IN = a; PSW_IN = p; ACC_LOAD = 1'b1; PSW_LOAD = 1'b1; ma = a; mp = p;
        @(posedge SYS_CLK);
        #1;
        ACC_LOAD = 1'b0; PSW_LOAD = 1'b0;
        chk("acc load", 16'(ACC_OUT), 16'(a));
        chk("psw load", 16'(PSW_OUT), 16'(p));
    endtask : load

    // One instruction; START and stale loads are held while busy and must be ignored
    task automatic run(input int op, src, bi, input logic f, input logic [7:0] m);
        int k;
        predict(ma, mp, m, op, src, bi, f);
        REQ = '{op: bit_logic_pkg::op_e'(op[3:0]), src: bit_logic_pkg::src_e'(src[2:0]),
                bit_idx: bi[2:0], fast_ram: f, mem_data: m};
        START = 1'b1;
        @(posedge SYS_CLK);
        #1;
        ACC_LOAD = 1'b1; PSW_LOAD = 1'b1; ACC_IN = ~ma; PSW_IN = ~mp;
        chk("ready busy", 16'(READY), 16'h0000);
        k = 1;
        while (DONE !== 1'b1 && k < 16) begin
            @(posedge SYS_CLK);
            #1;
            k++;
            if (k >= ecyc) begin START = 1'b0; ACC_LOAD = 1'b0; PSW_LOAD = 1'b0; end
        end
        if (DONE !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED done expected 1 seen %b", DONE);
            tally_and_finish();
        end
        chk("cycles", 16'(k), 16'(ecyc));
        @(posedge SYS_CLK);
        #1;
        START = 1'b0; ACC_LOAD = 1'b0; PSW_LOAD = 1'b0;
        chk("acc", 16'(ACC_OUT), 16'(ea));
        chk("psw", 16'(PSW_OUT), 16'(ep));
        chk("ready idle", 16'(READY), 16'h0001);
        chk("mem we", 16'(MEM_WR.we), 16'(ewe));
        if (ewe) chk("mem data", 16'(MEM_WR.data), 16'(emd));
        ma = ea; mp = ep;
    endtask : run

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (4) @(posedge SYS_CLK);
        #1;
        RESETN = 1'b1;
        chk("reset acc", 16'(ACC_OUT), 16'h0000);
        chk("reset psw", 16'(PSW_OUT), 16'h0000);
        chk("reset ready", 16'(READY), 16'h0001);
        for (int op = 0; op < 16; op++) begin
            for (int i = 0; i < 10; i++) begin
                rng = xs(rng);
                if (i % 2 == 0) load((i == 0) ? 8'h99 : rng[7:0], (i == 0) ? 8'h51 : rng[15:8]);
                run(op, i % 5, int'(rng[18:16]), (i < 5), rng[31:24]);
            end
            $display("test op %0d finished", op);
        end
        // Reset in mid-instruction abandons it and restores the reset state
        REQ = '{op: bit_logic_pkg::OP_NIB_R, src: bit_logic_pkg::SRC_PTR, bit_idx: 3'h0,
                fast_ram: 1'b0, mem_data: 8'hA5};
        START = 1'b1;
        repeat (3) @(posedge SYS_CLK);
        #1;
        START = 1'b0;
        RESETN = 1'b0;
        #1;
        chk("mid reset acc", 16'(ACC_OUT), 16'h0000);
        chk("mid reset psw", 16'(PSW_OUT), 16'h0000);
        chk("mid reset ready", 16'(READY), 16'h0001);
        chk("mid reset done", 16'(DONE), 16'h0000);
        chk("mid reset mem we", 16'(MEM_WR.we), 16'h0000);
        @(posedge SYS_CLK);
        #1;
        RESETN = 1'b1;
        ma = 8'h00;
        mp = 8'h00;
        run(3, 4, 0, 1'b0, 8'hC3);
        $display("test mid reset finished");
        tally_and_finish();
    end
endmodule : tb
